// ### design/sac_pkg.sv
// Shared constants and types for the SAR converter control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sac_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RESULT_IDX   = 8'hd0;
  localparam logic [7:0] CTRL_IDX     = 8'hd1;

  // Control register field positions
  localparam int unsigned IRQ_EN_BIT  = 7;
  localparam int unsigned EOC_BIT     = 6;
  localparam int unsigned START_BIT   = 5;
  localparam int unsigned PWR_BIT     = 4;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h40;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // First trial code of the approximation (MSB only)
  localparam logic [7:0] SAR_FIRST    = 8'h80;

  // Conversion timing at a 100 ns clock
  localparam int unsigned CONV_TIME_NS  = 70000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SAR_STEPS     = 8;
  localparam int unsigned STEP_CYCLES   = CONV_CYCLES / SAR_STEPS;
  localparam logic [6:0]  STEP_LAST     = 7'(STEP_CYCLES - 1);

  // Held control bits: software-written enable and power, hardware-set done flag
  typedef struct packed {
    logic irq_en;
    logic eoc;
    logic pwr;
  } sac_ctrl_t;

  localparam sac_ctrl_t CTRL_RESET_S = '{irq_en: CTRL_RESET[IRQ_EN_BIT],
                                         eoc:    CTRL_RESET[EOC_BIT],
                                         pwr:    CTRL_RESET[PWR_BIT]};

endpackage : sac_pkg

// ### design/sac_sync2.sv
// Two-flop synchroniser for the asynchronous comparator level
`timescale 1ns/10ps
`default_nettype none
module sac_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sac_sync2
`default_nettype wire

// ### design/sac_sar_seq.sv
// Successive approximation sequencer: trial code, bit decisions, result
`timescale 1ns/10ps
`default_nettype none
module sac_sar_seq
  import sac_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic       abort_in,
  input  wire logic       step_in,
  input  wire logic       cmp_in,
  output logic [7:0]      trial_out,
  output logic [7:0]      result_out,
  output logic            busy_out,
  output logic            done_out
);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } sac_seq_t;

  sac_seq_t   state_q;
  logic [7:0] mask_q;
  logic [7:0] decided;

  // Keep the trial bit if the input is at or above the trial level
  assign decided  = cmp_in ? trial_out : (trial_out & ~mask_q);
  assign busy_out = (state_q == SEQ_RUN);

  // One bit per step, MSB first; a start restarts from the MSB unless abort is high in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q   <= SEQ_IDLE;
      mask_q    <= SAR_FIRST;
      trial_out <= 8'h00;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        SEQ_IDLE: begin
          if (start_in && !abort_in) begin
            state_q   <= SEQ_RUN;
            mask_q    <= SAR_FIRST;
            trial_out <= SAR_FIRST;
          end
        end
        SEQ_RUN: begin
          if (abort_in) begin
            state_q <= SEQ_IDLE;
          end else if (start_in) begin
            mask_q    <= SAR_FIRST;
            trial_out <= SAR_FIRST;
          end else if (step_in) begin
            mask_q <= mask_q >> 1;
            if (mask_q[0]) begin
              state_q  <= SEQ_IDLE;
              done_out <= 1'b1;
            end else begin
              trial_out <= decided | (mask_q >> 1);
            end
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // Result changes only on the final decision
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_out <= RESULT_RESET;
    end else if (busy_out && !abort_in && !start_in && step_in && mask_q[0]) begin
      result_out <= decided;
    end
  end

  a_result_stable: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !(busy_out && step_in && mask_q[0]) |=> $stable(result_out))
    else $error("result changed outside conversion completion");

  a_msb_first: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (busy_out && step_in && !start_in && !abort_in && !mask_q[0])
      |=> mask_q == $past(mask_q) >> 1)
    else $error("trial bit did not advance toward lsb");

endmodule : sac_sar_seq
`default_nettype wire

// ### design/sac_top.sv
// Converter control top: Wishbone registers, step timing, power and wake logic
`timescale 1ns/10ps
`default_nettype none
module sac_top
  import sac_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  // Wishbone classic slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [31:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Analog side
  input  wire logic        CMP_IN,
  output logic [7:0]       DAC_CODE_OUT,
  output logic             CONV_POWER_OUT,
  // Core power modes and interrupt
  input  wire logic        WAIT_MODE_IN,
  input  wire logic        STOP_MODE_IN,
  output logic             IRQ_OUT,
  output logic             WAKE_OUT
);

  //----------------------------------------------------------------------------
  // Address decode
  //----------------------------------------------------------------------------

  // Byte address of a register index, one aligned word each
  function automatic logic hits(input logic [31:0] adr, input logic [7:0] idx);
    hits = (adr == {22'h000000, idx, 2'b00});
  endfunction : hits

  logic       ack_q;
  logic       bus_req;
  logic       bus_do;
  logic       wr_ctrl;
  logic       start_wr;
  logic       sel_ctrl;
  logic       sel_result;

  // A write is taken at the edge where ack is high, and only then
  assign bus_req    = WB_CYC_IN && WB_STB_IN;
  assign bus_do     = bus_req && ack_q;
  assign sel_ctrl   = hits(WB_ADR_IN, CTRL_IDX);
  assign sel_result = hits(WB_ADR_IN, RESULT_IDX);
  assign wr_ctrl    = bus_do && WB_WE_IN && WB_SEL_IN[0] && sel_ctrl;
  assign start_wr   = wr_ctrl && WB_DAT_IN[START_BIT];
  assign WB_ACK_OUT = ack_q;

  //----------------------------------------------------------------------------
  // Bus handshake
  //----------------------------------------------------------------------------

  // One wait state, then ack for one cycle; unmapped addresses ack too
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  //----------------------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------------------

  sac_ctrl_t  ctrl_q;
  logic       conv_en;
  logic       abort;
  logic       seq_busy;
  logic       seq_done;
  logic [7:0] result;

  // Converter runs only while powered and the core is not stopped
  assign conv_en = ctrl_q.pwr && !STOP_MODE_IN;
  assign abort   = !conv_en;

  // Software-writable enable and power bits
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q.irq_en <= CTRL_RESET_S.irq_en;
      ctrl_q.pwr    <= CTRL_RESET_S.pwr;
    end else if (wr_ctrl) begin
      ctrl_q.irq_en <= WB_DAT_IN[IRQ_EN_BIT];
      ctrl_q.pwr    <= WB_DAT_IN[PWR_BIT];
    end
  end

  // Done flag: a start clears it and beats a completion in the same cycle,
  // because that start begins a new conversion after the finished one
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q.eoc <= CTRL_RESET_S.eoc;
    end else if (start_wr) begin
      ctrl_q.eoc <= 1'b0;
    end else if (seq_done) begin
      ctrl_q.eoc <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------------------

  logic [7:0] rd_byte;

  // Start bit and reserved low bits always read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (sel_ctrl) begin
      rd_byte[IRQ_EN_BIT] = ctrl_q.irq_en;
      rd_byte[EOC_BIT]    = ctrl_q.eoc;
      rd_byte[START_BIT]  = 1'b0;
      rd_byte[PWR_BIT]    = ctrl_q.pwr;
    end else if (sel_result) begin
      rd_byte = result;
    end
  end

  // Data captured with the request so it stands while ack is high
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WB_DAT_OUT <= 32'h00000000;
    end else if (bus_req && !ack_q && !WB_WE_IN) begin
      WB_DAT_OUT <= {24'h000000, rd_byte};
    end else if (!bus_req) begin
      WB_DAT_OUT <= 32'h00000000;
    end
  end

  //----------------------------------------------------------------------------
  // Step timing
  //----------------------------------------------------------------------------

  logic [6:0] step_cnt_q;
  logic       step_en;

  // Each bit gets a full settle period; a start realigns the divider so a
  // restarted conversion never inherits a short first step
  assign step_en = seq_busy && (step_cnt_q == STEP_LAST);

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      step_cnt_q <= 7'h00;
    end else if (start_wr || !seq_busy || step_en) begin
      step_cnt_q <= 7'h00;
    end else begin
      step_cnt_q <= step_cnt_q + 7'h01;
    end
  end

  //----------------------------------------------------------------------------
  // Comparator and sequencer
  //----------------------------------------------------------------------------

  logic cmp_sync;

  // Comparator is analog and asynchronous to the clock
  sac_sync2 u_cmp_sync (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .async_in (CMP_IN),
    .sync_out (cmp_sync)
  );

  // One start write gives one conversion
  sac_sar_seq u_seq (
    .clk_in     (CLOCK_IN),
    .rst_n_in   (RST_N_IN),
    .start_in   (start_wr),
    .abort_in   (abort),
    .step_in    (step_en),
    .cmp_in     (cmp_sync),
    .trial_out  (DAC_CODE_OUT),
    .result_out (result),
    .busy_out   (seq_busy),
    .done_out   (seq_done)
  );

  //----------------------------------------------------------------------------
  // Power, interrupt and wake
  //----------------------------------------------------------------------------

  // Wait mode does not touch the converter; stop mode removes power
  assign CONV_POWER_OUT = conv_en;

  // Level request; it stays up until enable is cleared or a new start
  assign IRQ_OUT = ctrl_q.eoc && ctrl_q.irq_en;

  // Wake only out of wait; a stopped core is never woken by the converter
  assign WAKE_OUT = IRQ_OUT && WAIT_MODE_IN && !STOP_MODE_IN;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------

  a_start_clears_eoc: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    start_wr |=> !ctrl_q.eoc && (seq_busy || !conv_en))
    else $error("start did not clear done flag or begin conversion");

  a_done_sets_eoc: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (seq_done && !start_wr) |=> ctrl_q.eoc)
    else $error("completion did not set done flag");

  a_irq_on_eoc: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (seq_done && !start_wr && !wr_ctrl && ctrl_q.irq_en) |=> IRQ_OUT)
    else $error("no interrupt request on done with enable set");

  a_restart_msb: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (start_wr && seq_busy && conv_en) |=> seq_busy && DAC_CODE_OUT == SAR_FIRST)
    else $error("start during conversion did not restart from msb");

  a_start_reads_zero: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (ack_q && !WB_WE_IN && sel_ctrl) |-> !WB_DAT_OUT[START_BIT])
    else $error("start bit read back as one");

  a_single_shot: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (seq_done && !start_wr) |-> !seq_busy ##1 (!seq_busy || $past(start_wr)))
    else $error("conversion restarted without a start write");

  a_eoc_sticky: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (ctrl_q.eoc && !start_wr) |=> ctrl_q.eoc)
    else $error("done flag cleared without a start");

  a_power_off_idle: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !conv_en |=> !seq_busy)
    else $error("sequencer kept running while converter off");

  a_stop_no_wake: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    STOP_MODE_IN |-> !WAKE_OUT && !CONV_POWER_OUT)
    else $error("converter active or wake raised in stop mode");

  a_wait_wakes: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (WAIT_MODE_IN && !STOP_MODE_IN && IRQ_OUT) |-> WAKE_OUT)
    else $error("done interrupt did not wake from wait");

  a_step_period: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    step_en |=> !step_en)
    else $error("step pulses closer than the settle period");

endmodule : sac_top
`default_nettype wire

// ### tb/sac_analog_model.sv
// Analog side model: one input level seen through the comparator
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model
  import sac_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       power_in,
  input  wire logic [7:0] dac_in,
  input  wire logic [8:0] level_in,
  output logic            cmp_out
);
  //----------------------------------------------------------------------------
  // Comparator
  //----------------------------------------------------------------------------
  logic junk_q = 1'b0;

  // Unpowered comparator output wanders, so a stale decision never looks valid
  always_ff @(posedge clk_in) begin
    junk_q <= ~junk_q;
  end

  // Level 256 stands for an input at or above the high reference
  // Only one input level exists, so no two lines are ever selected together
  assign cmp_out = power_in ? (level_in >= {1'b0, dac_in}) : junk_q;
endmodule : sac_analog_model
`default_nettype wire

// ### tb/sar_adc_control_bench.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_bench
  import sac_pkg::*;
;
  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  localparam logic [31:0] ADR_RES  = {22'h0, RESULT_IDX, 2'b00};
  localparam logic [31:0] ADR_CTRL = {22'h0, CTRL_IDX, 2'b00};
  logic        clk, rst_n, cyc, stb, we, ack, cmp, pwr, irq, wake, wait_m, stop_m;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  sel;
  logic [7:0]  dac;
  logic [8:0]  level;
  int          error_cnt, n_tests;

  // Clock at 100 ns period
  always #50 clk = ~clk;

  sac_top dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CMP_IN(cmp), .DAC_CODE_OUT(dac),
    .CONV_POWER_OUT(pwr), .WAIT_MODE_IN(wait_m), .STOP_MODE_IN(stop_m),
    .IRQ_OUT(irq), .WAKE_OUT(wake));

  sac_analog_model model (.clk_in(clk), .power_in(pwr), .dac_in(dac),
    .level_in(level), .cmp_out(cmp));

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle; ack and data are taken at the edge that shows ack high
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= 4'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk("bus ack", 8'h01, 8'h00);
  endtask : wb

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask : rd_chk

  // Poll the done flag with a bound well past one conversion
  task automatic wait_done();
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_CTRL, 8'h00, q);
      n++;
    end while (q[EOC_BIT] !== 1'b1 && n < 400);
    chk("done flag", 8'h01, {7'h0, q[EOC_BIT]});
  endtask : wait_done

  // Power on first, start in a separate write, then check the first trial and the result
  task automatic convert(input logic [8:0] lvl, input logic [7:0] exp);
    level <= lvl;
    wr(ADR_CTRL, 8'h10);
    wr(ADR_CTRL, 8'h30);
    repeat (2) @(posedge clk);
    chk("first trial", 8'h80, dac);
    rd_chk("ctrl after start", ADR_CTRL, 8'h10);
    wait_done();
    rd_chk("result", ADR_RES, exp);
  endtask : convert

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("ctrl reset", ADR_CTRL, CTRL_RESET);
    rd_chk("result reset", ADR_RES, RESULT_RESET);
    wr(ADR_RES, 8'h5a);
    rd_chk("result read-only", ADR_RES, RESULT_RESET);
    rd_chk("unmapped", ADR_CTRL + 32'h4, 8'h00);
    chk("power at reset", 8'h00, {7'h0, pwr});
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes();
    logic [8:0] lv [6] = '{9'h000, 9'h001, 9'h05a, 9'h05b, 9'h0ff, 9'h100};
    logic [7:0] ex [6] = '{8'h00, 8'h01, 8'h5a, 8'h5b, 8'hff, 8'hff};
    for (int i = 0; i < 6; i++) begin
      convert(lv[i], ex[i]);
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_irq_wait();
    int n;
    wait_m <= 1'b1;
    level  <= 9'h033;
    wr(ADR_CTRL, 8'h90);
    wr(ADR_CTRL, 8'hb0);
    @(posedge clk);
    chk("irq after start", 8'h00, {7'h0, irq});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 1000);
    chk("irq at done", 8'h01, {7'h0, irq});
    chk("wake in wait", 8'h01, {7'h0, wake});
    rd_chk("ctrl done", ADR_CTRL, 8'hd0);
    wr(ADR_CTRL, 8'h90);
    rd_chk("done kept", ADR_CTRL, 8'hd0);
    wr(ADR_CTRL, 8'h10);
    @(posedge clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    // A new level would show up in the result only if a conversion restarted
    level <= 9'h077;
    repeat (800) @(posedge clk);
    rd_chk("ctrl idle", ADR_CTRL, 8'h50);
    rd_chk("result kept", ADR_RES, 8'h33);
    wait_m <= 1'b0;
    $display("test irq and wait done");
  endtask : t_irq_wait

  task automatic t_restart();
    level <= 9'h010;
    wr(ADR_CTRL, 8'h30);
    repeat (300) @(posedge clk);
    level <= 9'h0c4;
    rd_chk("result mid-run", ADR_RES, 8'h33);
    wr(ADR_CTRL, 8'h30);
    repeat (2) @(posedge clk);
    chk("restart trial", 8'h80, dac);
    repeat (600) @(posedge clk);
    rd_chk("no early done", ADR_CTRL, 8'h10);
    wait_done();
    rd_chk("restart result", ADR_RES, 8'hc4);
    $display("test restart done");
  endtask : t_restart

  task automatic t_power();
    level <= 9'h020;
    wr(ADR_CTRL, 8'h20);
    @(posedge clk);
    chk("power off", 8'h00, {7'h0, pwr});
    repeat (800) @(posedge clk);
    rd_chk("no conv off", ADR_CTRL, 8'h00);
    wr(ADR_CTRL, 8'h90);
    @(posedge clk);
    chk("power on", 8'h01, {7'h0, pwr});
    wr(ADR_CTRL, 8'hb0);
    repeat (200) @(posedge clk);
    stop_m <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk("power in stop", 8'h00, {7'h0, pwr});
    repeat (800) @(posedge clk);
    rd_chk("no done in stop", ADR_CTRL, 8'h90);
    chk("no irq in stop", 8'h00, {7'h0, irq});
    rd_chk("result after stop", ADR_RES, 8'hc4);
    stop_m <= 1'b0;
    $display("test power and stop done");
  endtask : t_power

  //----------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  //----------------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Main run: all inputs defined at time zero, reset held for five cycles
  initial begin
    clk = 1'b0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 32'h0; wdat = 32'h0; sel = 4'h0; level = 9'h000;
    wait_m = 1'b0; stop_m = 1'b0; error_cnt = 0; n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_irq_wait();
    t_restart();
    t_power();
    stop_test();
  end

  // Whole run needs about 9000 cycles; a hang ends at the bound, over four times that
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("FAIL watchdog expected finish seen timeout");
    stop_test();
  end
endmodule : sar_adc_control_bench
`default_nettype wire
